// ---- logic/cca_cfg.svh ----
// Constants for the cache control block: field positions, resets, sizes
`ifndef CCA_CFG_SVH
`define CCA_CFG_SVH

// ----------------------------------------------------------------------
// Control word field positions
// ----------------------------------------------------------------------
`define CCA_BIT_CACHE_ENABLE 31
`define CCA_BIT_STORE_BUF    29
`define CCA_BIT_PUSH_KEEP    28
`define CCA_BIT_HALF_LOCK    27
`define CCA_BIT_INVAL_ALL    24
`define CCA_BIT_NFB_DEFAULT  10
`define CCA_DCM_HI           9
`define CCA_DCM_LO           8
`define CCA_BIT_WPROT        5

// ----------------------------------------------------------------------
// Reset value and mask of bits that hold state (reserved bits read 0)
// ----------------------------------------------------------------------
`define CCA_CTRL_RESET       32'h0000_0000
`define CCA_CTRL_WMASK       32'hb800_0720

// ----------------------------------------------------------------------
// Geometry and encodings
// ----------------------------------------------------------------------
`define CCA_NUM_SETS         128
`define CCA_LINE_W           28
`define CCA_TT_NORMAL        2'h0
`define CCA_RR_RESET         2'h0
`define CCA_RR_HALF_STEP     2'h2

`endif

// ---- logic/cca_pkg.sv ----
// Types shared by the cache control block
package cca_pkg;

  // Default cache mode encodings
  typedef enum logic [1:0] {
    CCA_DCM_WTHRU    = 2'b00,
    CCA_DCM_COPYBACK = 2'b01,
    CCA_DCM_INH_PREC = 2'b10,
    CCA_DCM_INH_IMPR = 2'b11
  } cca_dcm_t;

  // Invalidate sweep states
  typedef enum logic {
    CCA_ST_IDLE  = 1'b0,
    CCA_ST_SWEEP = 1'b1
  } cca_state_t;

  typedef logic [1:0] cca_way_t;

endpackage

// ---- logic/cca_alloc_if.sv ----
// Interface between the control core and the way allocator
`timescale 1ns/1ns
`default_nettype none
interface cca_alloc_if;
  import cca_pkg::*;
  logic       req;        // Allocation request, one cycle
  logic [3:0] way_valid;  // Valid flags of the addressed set
  logic       half_lock;  // Locking mode in force
  cca_way_t   way;        // Chosen way, registered
  logic       grant;      // Chosen way is on way, one cycle
  logic [1:0] rr;         // Round-robin counter, for status
  modport ctrl  (output req, way_valid, half_lock,
                 input  way, grant, rr);
  modport alloc (input  req, way_valid, half_lock,
                 output way, grant, rr);
endinterface
`default_nettype wire

// ---- logic/cca_way_alloc.sv ----
// Way allocator with round-robin replacement and half-lock mode
`timescale 1ns/1ns
`default_nettype none
`include "cca_cfg.svh"
module cca_way_alloc (
  // Clock and reset
  input  wire logic   clock_in,
  input  wire logic   rst_n_in,
  // Link to the control core
  cca_alloc_if.alloc  al
);
  import cca_pkg::*;

  logic [1:0] rr_q;
  logic [1:0] rr_d;
  cca_way_t   way_q;
  cca_way_t   pick;
  logic       grant_q;
  logic       full;

  // --------------------------------------------------------------------
  // Way choice
  // --------------------------------------------------------------------
  // Eligible ways depend only on the mode seen this cycle, so the lock
  // may change at any time without a flush
  always_comb begin
    full = 1'b0;
    rr_d = rr_q;
    pick = 2'd0;
    if (!al.half_lock) begin
      if (!al.way_valid[0]) pick = 2'd0;        // R1
      else if (!al.way_valid[1]) pick = 2'd1;   // R1
      else if (!al.way_valid[2]) pick = 2'd2;   // R1
      else if (!al.way_valid[3]) pick = 2'd3;   // R1
      else begin
        full = 1'b1;
        pick = rr_q;                            // R1
        rr_d = rr_q + 2'd1;                     // R17
      end
    end else begin
      if (!al.way_valid[2]) pick = 2'd2;        // R2 R3
      else if (!al.way_valid[3]) pick = 2'd3;   // R2 R3
      else begin
        full = 1'b1;
        pick = rr_q[1] ? 2'd3 : 2'd2;           // R2
        rr_d = rr_q ^ `CCA_RR_HALF_STEP;        // R2
      end
    end
  end

  // Counter moves only when every eligible way was valid
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) rr_q <= `CCA_RR_RESET;
    else if (al.req && full) rr_q <= rr_d;      // R17
  end

  // Registered answer
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      way_q   <= 2'd0;
      grant_q <= 1'b0;
    end else begin
      grant_q <= al.req;
      if (al.req) way_q <= pick;
    end
  end

  assign al.way   = way_q;
  assign al.grant = grant_q;
  assign al.rr    = rr_q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  lock_keeps_low_a: assert property (                       // R3
    al.req && al.half_lock |=> al.grant && al.way[1])
    else $error("allocation hit a locked way");
  lowest_invalid_a: assert property (                       // R1
    al.req && !al.half_lock && !al.way_valid[0] |=> al.way == 2'd0)
    else $error("lowest invalid way not chosen");
  half_pick_a: assert property (                            // R2
    al.req && al.half_lock && (&al.way_valid[3:2])
    |=> al.way == ($past(rr_q[1]) ? 2'd3 : 2'd2))
    else $error("half-lock victim wrong");
  rr_steady_a: assert property (                            // R17
    !(al.req && full) |=> $stable(rr_q))
    else $error("counter moved without a full set");
  rr_mod4_a: assert property (                              // R1
    al.req && !al.half_lock && (&al.way_valid)
    |=> rr_q == $past(rr_q) + 2'd1)
    else $error("counter did not advance modulo four");
endmodule
`default_nettype wire

// ---- logic/cca_cache_ctrl.sv ----
// Cache control word, whole-cache invalidate sweep and fill buffer gate
`timescale 1ns/1ns
`default_nettype none
`include "cca_cfg.svh"

// Notes on behaviour
// [R1] Unlocked, a new line goes to the lowest invalid way, else to the counter's way, and the counter steps modulo four.
// [R2] Half-locked, the lower invalid of ways 2 and 3 is used, else way 2 or 3 by the counter's high bit, which then toggles.
// [R3] Half-locked, ways 0 and 1 are never allocated, though they still take write hits and explicit maintenance.
// [R4] The half-lock bit may change at any time with no flush or special sequence.
// [R5] Writing one to the invalidate-all bit starts a full invalidate, zero does nothing, and the bit clears itself when done.
// [R6] The sweep visits every set in order and clears valid and modified flags of each line.
// [R7] Cache accesses stall while the sweep runs, and the invalidate-all bit drops as it ends.
// [R8] Reset never clears tags, valid flags or data; only the invalidate command does.
// [R9] Software should push modified copy-back lines before invalidating all.
// [R10] With the fill buffer default bit clear, noncacheable instruction fetches are not kept in the fill buffer.
// [R11] With it set, only normal noncacheable instruction reads of transfer type zero are kept.
// [R12] Those are fetched by burst and kept until displaced, so later hits make no external cycle.
// [R13] Writes go out without touching the fill buffer, so later reads may see stale data.
// [R14] Software writes zero to the reserved bits 26 to 25 and 23 to 11.
// [R15] The default cache mode field selects write-through, copy-back, inhibited precise or inhibited imprecise.
// [R16] Hardware reset clears the whole control word, disabling the cache, and leaves cache contents alone.
// [R17] The two-bit counter steps only when no eligible way is invalid.
module cca_cache_ctrl #(
  parameter int NUM_SETS = `CCA_NUM_SETS,
  parameter int LINE_W   = `CCA_LINE_W,
  parameter int SET_W    = $clog2(`CCA_NUM_SETS)
) (
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  // Control word access (core move-to-control and debug)
  input  wire logic              ctrl_wr_in,
  input  wire logic [31:0]       ctrl_wdata_in,
  output logic [31:0]            ctrl_rdata_out,
  // Decoded control fields
  output logic                   cache_enable_out,
  output logic                   store_buf_en_out,
  output logic                   push_keep_valid_out,
  output logic                   write_protect_out,
  output cca_pkg::cca_dcm_t      default_cache_mode_out,
  output logic                   dflt_cacheable_out,
  output logic                   dflt_copyback_out,
  output logic                   dflt_precise_out,
  // Core access stall
  input  wire logic              access_req_in,
  output logic                   access_stall_out,
  // Line allocation
  input  wire logic              alloc_req_in,
  input  wire logic [3:0]        alloc_way_valid_in,
  output cca_pkg::cca_way_t      alloc_way_out,
  output logic                   alloc_done_out,
  output logic [1:0]             alloc_rr_out,
  // Invalidate sweep towards the tag array
  output logic                   inval_clear_out,
  output logic [SET_W-1:0]       inval_set_out,
  // Instruction fetch and fill buffer
  input  wire logic              fetch_req_in,
  input  wire logic              fetch_noncache_in,
  input  wire logic [1:0]        fetch_tt_in,
  input  wire logic [LINE_W-1:0] fetch_line_in,
  output logic                   fb_hit_out,
  output logic                   fb_burst_out,
  output logic                   fb_single_out,
  input  wire logic              fb_fill_done_in,
  input  wire logic [LINE_W-1:0] fb_fill_line_in,
  input  wire logic              line_fill_in,
  // Operand writes, seen only to show they leave the buffer alone
  input  wire logic              op_write_in,
  input  wire logic [LINE_W-1:0] op_line_in
);
  import cca_pkg::*;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Mode decode is used for the outputs; the mode check below reads them
  function automatic logic [2:0] dcm_decode(input cca_dcm_t m);
    logic [2:0] r;
    r = 3'b000;
    case (m)
      CCA_DCM_WTHRU:    r = 3'b101;  // Cacheable, precise writes
      CCA_DCM_COPYBACK: r = 3'b111;  // Cacheable, copy-back
      CCA_DCM_INH_PREC: r = 3'b001;  // Inhibited, precise
      CCA_DCM_INH_IMPR: r = 3'b000;  // Inhibited, imprecise
      default:          r = 3'b000;
    endcase
    return r;
  endfunction

  localparam logic [SET_W-1:0] LAST_SET = SET_W'(NUM_SETS - 1);

  logic [31:0]       ctrl_q;
  cca_state_t        state_q;
  logic [SET_W-1:0]  set_q;
  logic              sweeping;
  logic              start;
  logic              fb_valid_q;
  logic [LINE_W-1:0] fb_line_q;
  logic              nfb;
  logic              nc_fetch;
  logic              fb_eligible;
  logic [2:0]        mode_bits;

  cca_alloc_if alloc_bus ();

  // --------------------------------------------------------------------
  // Control word
  // --------------------------------------------------------------------
  // Only defined bits hold state; reserved bits are dropped and read 0.
  // The invalidate bit is not stored: it is the sweep's busy flag.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) ctrl_q <= `CCA_CTRL_RESET;                   // R16
    else if (ctrl_wr_in) ctrl_q <= ctrl_wdata_in & `CCA_CTRL_WMASK;
  end

  assign start    = ctrl_wr_in && ctrl_wdata_in[`CCA_BIT_INVAL_ALL]; // R5
  assign sweeping = (state_q == CCA_ST_SWEEP);
  assign nfb      = ctrl_q[`CCA_BIT_NFB_DEFAULT];

  // Read-back shows the live sweep state in the invalidate bit
  always_comb begin
    ctrl_rdata_out = ctrl_q;
    ctrl_rdata_out[`CCA_BIT_INVAL_ALL] = sweeping;              // R5 R7
  end

  // Field outputs
  assign cache_enable_out       = ctrl_q[`CCA_BIT_CACHE_ENABLE];
  assign store_buf_en_out       = ctrl_q[`CCA_BIT_STORE_BUF];
  assign push_keep_valid_out    = ctrl_q[`CCA_BIT_PUSH_KEEP];
  assign write_protect_out      = ctrl_q[`CCA_BIT_WPROT];
  assign default_cache_mode_out =
    cca_dcm_t'(ctrl_q[`CCA_DCM_HI:`CCA_DCM_LO]);
  assign mode_bits              = dcm_decode(default_cache_mode_out); // R15
  assign dflt_cacheable_out     = mode_bits[2];                 // R15
  assign dflt_copyback_out      = mode_bits[1];                 // R15
  assign dflt_precise_out       = mode_bits[0];                 // R15

  // --------------------------------------------------------------------
  // Invalidate sweep
  // --------------------------------------------------------------------
  // One set per cycle. A new start wins over the last cycle, so a
  // command that lands as a sweep ends is never lost. Tags live outside
  // and are never touched by reset; only this sweep clears them.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= CCA_ST_IDLE;
      set_q   <= '0;
    end else begin
      case (state_q)
        CCA_ST_IDLE: begin
          if (start) begin                                      // R5
            state_q <= CCA_ST_SWEEP;
            set_q   <= '0;
          end
        end
        CCA_ST_SWEEP: begin
          if (start) begin
            set_q <= '0;
          end else if (set_q == LAST_SET) begin
            state_q <= CCA_ST_IDLE;                             // R7
            set_q   <= '0;
          end else begin
            set_q <= set_q + 1'b1;                              // R6
          end
        end
        default: begin
          state_q <= CCA_ST_IDLE;
          set_q   <= '0;
        end
      endcase
    end
  end

  // Tag array clears valid and modified of all ways at this set
  assign inval_clear_out  = sweeping;                           // R6 R8
  assign inval_set_out    = set_q;
  assign access_stall_out = access_req_in && sweeping;          // R7

  // --------------------------------------------------------------------
  // Allocation
  // --------------------------------------------------------------------
  // Requests are held off during a sweep; the lock bit goes straight
  // through, so changing it needs no flush
  assign alloc_bus.req       = alloc_req_in && !sweeping;       // R7
  assign alloc_bus.way_valid = alloc_way_valid_in;
  assign alloc_bus.half_lock = ctrl_q[`CCA_BIT_HALF_LOCK];      // R4
  assign alloc_way_out       = alloc_bus.way;
  assign alloc_done_out      = alloc_bus.grant;
  assign alloc_rr_out        = alloc_bus.rr;

  cca_way_alloc u_alloc (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .al       (alloc_bus.alloc)
  );

  // --------------------------------------------------------------------
  // Fill buffer for noncacheable fetches
  // --------------------------------------------------------------------
  assign nc_fetch    = fetch_req_in && fetch_noncache_in;
  assign fb_eligible = nfb && (fetch_tt_in == `CCA_TT_NORMAL);  // R11
  assign fb_hit_out  = nc_fetch && fb_eligible && fb_valid_q &&
                       (fb_line_q == fetch_line_in);            // R12
  assign fb_burst_out  = nc_fetch && fb_eligible && !fb_hit_out; // R12
  assign fb_single_out = nc_fetch && !fb_eligible;              // R10

  // Kept until displaced by a cacheable line fill or the mode is
  // turned off. Operand writes are deliberately ignored: self-modifying
  // code can read stale instructions here. A burst ending as a line
  // fill displaces wins, so freshly fetched code is not thrown away.
  always_ff @(posedge clock_in or negedge rst_n_in) begin     // R13
    if (!rst_n_in) begin
      fb_valid_q <= 1'b0;
      fb_line_q  <= '0;
    end else if (!nfb) begin
      fb_valid_q <= 1'b0;                                       // R10
    end else if (fb_fill_done_in) begin
      fb_valid_q <= 1'b1;                                       // R12
      fb_line_q  <= fb_fill_line_in;
    end else if (line_fill_in) begin
      fb_valid_q <= 1'b0;                                       // R12
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // Start of a sweep, then the walk over its first two sets
  sequence sweep_begins;
    ctrl_wr_in && ctrl_wdata_in[`CCA_BIT_INVAL_ALL];
  endsequence
  sequence sweep_first_sets;
    inval_clear_out && inval_set_out == '0 ##1
    inval_clear_out && inval_set_out == SET_W'(1);
  endsequence

  // Start lands on set zero
  sweep_start_a: assert property (                             // R5
    sweep_begins |=> sweep_first_sets)
    else $error("sweep did not start at set zero");

  // One set per cycle
  sweep_step_a: assert property (                              // R6
    sweeping && !start && set_q != LAST_SET
    |=> sweeping && set_q == $past(set_q) + 1'b1)
    else $error("sweep skipped a set");

  // Busy bit and stall drop together
  sweep_end_a: assert property (                               // R7
    sweeping && !start && set_q == LAST_SET
    |=> !ctrl_rdata_out[`CCA_BIT_INVAL_ALL] && !access_stall_out)
    else $error("invalidate bit did not clear at end");

  // A zero write starts nothing
  zero_no_start_a: assert property (                           // R5
    !sweeping && !start |=> !sweeping)
    else $error("sweep began without a command");

  // Accesses wait for the sweep
  stall_busy_a: assert property (                              // R7
    access_req_in && sweeping |-> access_stall_out && !alloc_bus.req)
    else $error("access not stalled during sweep");

  // No grant comes out of a sweep
  alloc_held_a: assert property (                              // R7
    sweeping |=> !alloc_done_out)
    else $error("allocation granted during sweep");

  // Buffer idle with the mode off
  fb_off_a: assert property (                                  // R10
    !nfb |-> !fb_hit_out && !fb_burst_out)
    else $error("fill buffer used with mode off");

  // Only normal fetches use it
  fb_tt_a: assert property (                                   // R11
    fb_burst_out || fb_hit_out |-> fetch_tt_in == `CCA_TT_NORMAL)
    else $error("fill buffer used for other transfer type");

  // A loaded line is served with no bus cycle
  fb_keep_a: assert property (                                 // R12
    nfb && fb_fill_done_in ##1
    nfb && !line_fill_in && !fb_fill_done_in ##1
    nc_fetch && fb_eligible && fetch_line_in == $past(fb_fill_line_in, 2)
    |-> fb_hit_out && !fb_burst_out)
    else $error("buffered fetch went to the bus");

  // Writes leave the buffer alone
  fb_write_a: assert property (                                // R13
    op_write_in && op_line_in == fb_line_q && nfb && !line_fill_in &&
    !fb_fill_done_in |=> $stable(fb_valid_q) && $stable(fb_line_q))
    else $error("write altered the fill buffer");

  // Copy-back decodes as cacheable
  mode_a: assert property (                                    // R15
    default_cache_mode_out == CCA_DCM_COPYBACK
    |-> dflt_cacheable_out && dflt_copyback_out)
    else $error("copy-back default decoded wrong");
endmodule
`default_nettype wire

// ---- sim/cca_core_model.sv ----
// Core fetch model: issues instruction fetches and completes burst fills
`timescale 1ns/1ns
`default_nettype none
module cca_core_model #(
  parameter int LINE_W = 28
) (
  // Clock and fill buffer answers
  input  wire logic              clock_in,
  input  wire logic              fb_hit_in,
  input  wire logic              fb_burst_in,
  input  wire logic              fb_single_in,
  // Fetch and fill drive
  output logic                   fetch_req_out,
  output logic                   fetch_nc_out,
  output logic [1:0]             fetch_tt_out,
  output logic [LINE_W-1:0]      fetch_line_out,
  output logic                   fill_done_out,
  output logic [LINE_W-1:0]      fill_line_out
);
  // Released lines show the inverse, so stale values never match by luck
  initial begin
    fetch_req_out  = 1'b0;
    fetch_nc_out   = 1'b0;
    fetch_tt_out   = 2'h0;
    fetch_line_out = '0;
    fill_done_out  = 1'b0;
    fill_line_out  = '1;
  end
  // One fetch; a burst ends after gap cycles, so fills are slow or prompt
  task automatic fetch(input logic nc, input logic [1:0] tt,
                       input logic [LINE_W-1:0] line, input int gap,
                       output logic [2:0] seen);
    @(negedge clock_in);
    fetch_req_out  = 1'b1;
    fetch_nc_out   = nc;
    fetch_tt_out   = tt;
    fetch_line_out = line;
    #1;
    seen = {fb_hit_in, fb_burst_in, fb_single_in};
    @(negedge clock_in);
    fetch_req_out  = 1'b0;
    fetch_line_out = ~line;
    if (seen[1] === 1'b1) begin
      repeat (gap) @(negedge clock_in);
      fill_done_out = 1'b1;
      fill_line_out = line;
      @(negedge clock_in);
      fill_done_out = 1'b0;
      fill_line_out = ~line;
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/cca_cache_ctrl_tb.sv ----
// Self-checking bench for the cache control block
`timescale 1ns/1ns
`default_nettype none
module cca_cache_ctrl_tb;
  import cca_pkg::*;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  localparam int NSETS = 128;
  localparam logic [27:0] LINE_A = 28'h00a_5c31;
  localparam logic [3:0] PLAIN [9] = '{4'h0, 4'h5, 4'hb, 4'h7, 4'hf,
                                       4'hf, 4'hf, 4'hf, 4'hf};
  localparam logic [4:0] LOCKED [9] = '{5'h10, 5'h14, 5'h18, 5'h1f, 5'h1f,
                                        5'h1f, 5'h0f, 5'h1f, 5'h13};
  logic        clock_in, rst_n_in, ctrl_wr_in, access_req_in, alloc_req_in;
  logic        cache_enable_out, store_buf_en_out, push_keep_valid_out;
  logic        write_protect_out, dflt_cacheable_out, dflt_copyback_out;
  logic        dflt_precise_out, access_stall_out, alloc_done_out;
  logic        inval_clear_out, fetch_req_in, fetch_noncache_in, fb_hit_out;
  logic        fb_burst_out, fb_single_out, fb_fill_done_in, line_fill_in;
  logic        op_write_in, cur_lock;
  logic [31:0] ctrl_wdata_in, ctrl_rdata_out;
  logic [27:0] fetch_line_in, fb_fill_line_in, op_line_in;
  logic [6:0]  inval_set_out;
  logic [3:0]  alloc_way_valid_in;
  logic [1:0]  fetch_tt_in, alloc_rr_out, exp_rr;
  cca_dcm_t    default_cache_mode_out;
  cca_way_t    alloc_way_out;
  int          bad_count, checks;

  cca_cache_ctrl dut (.clock_in, .rst_n_in, .ctrl_wr_in, .ctrl_wdata_in,
    .ctrl_rdata_out, .cache_enable_out, .store_buf_en_out,
    .push_keep_valid_out, .write_protect_out, .default_cache_mode_out,
    .dflt_cacheable_out, .dflt_copyback_out, .dflt_precise_out,
    .access_req_in, .access_stall_out, .alloc_req_in, .alloc_way_valid_in,
    .alloc_way_out, .alloc_done_out, .alloc_rr_out, .inval_clear_out,
    .inval_set_out, .fetch_req_in, .fetch_noncache_in, .fetch_tt_in,
    .fetch_line_in, .fb_hit_out, .fb_burst_out, .fb_single_out,
    .fb_fill_done_in, .fb_fill_line_in, .line_fill_in, .op_write_in,
    .op_line_in);
  cca_core_model core (.clock_in, .fb_hit_in(fb_hit_out),
    .fb_burst_in(fb_burst_out), .fb_single_in(fb_single_out),
    .fetch_req_out(fetch_req_in), .fetch_nc_out(fetch_noncache_in),
    .fetch_tt_out(fetch_tt_in), .fetch_line_out(fetch_line_in),
    .fill_done_out(fb_fill_done_in), .fill_line_out(fb_fill_line_in));

  // Free-running 100 MHz clock
  always #5 clock_in = ~clock_in;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bits(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobe is one cycle; the word is readable at the following falling edge
  task automatic wr_ctrl(input logic [31:0] d);
    @(negedge clock_in);
    ctrl_wr_in    = 1'b1;
    ctrl_wdata_in = d;
    cur_lock      = d[27];
    @(negedge clock_in);
    ctrl_wr_in    = 1'b0;
    ctrl_wdata_in = ~d & 32'hfeff_ffff;
  endtask
  // Request is held until granted, since a sweep refuses it silently
  task automatic do_alloc(input logic lk, input logic [3:0] v);
    logic [1:0] w;
    int n;
    n = 0;
    if (lk) begin
      w = !v[2] ? 2'h2 : !v[3] ? 2'h3 : {1'b1, exp_rr[1]};
    end else begin
      w = !v[0] ? 2'h0 : !v[1] ? 2'h1 : !v[2] ? 2'h2 : !v[3] ? 2'h3 : exp_rr;
    end
    if (lk !== cur_lock) wr_ctrl({4'h0, lk, 27'h0});
    @(negedge clock_in);
    alloc_req_in       = 1'b1;
    alloc_way_valid_in = v;
    @(negedge clock_in);
    while (alloc_done_out !== 1'b1 && n < 300) begin
      @(negedge clock_in);
      n++;
    end
    if (n == 300) begin
      bad_count++;
      complete_run();
    end
    alloc_req_in       = 1'b0;
    alloc_way_valid_in = ~v;
    if (v == 4'hf || (lk && v[3:2] == 2'h3)) begin
      exp_rr = lk ? exp_rr ^ 2'h2 : exp_rr + 2'h1;
    end
    cmp_bits({4'h0, alloc_rr_out, alloc_way_out},
             {4'h0, exp_rr, w});
  endtask
  task automatic t_reset();
    rst_n_in = 1'b0;
    exp_rr   = 2'h0;
    cur_lock = 1'b0;
    repeat (2) @(negedge clock_in);
    cmp_word(ctrl_rdata_out, 32'h0);
    cmp_bits({5'h0, inval_clear_out, alloc_rr_out}, 8'h0);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clock_in);
    cmp_bits({7'h0, inval_clear_out}, 8'h0);
  endtask
  task automatic t_fields();
    wr_ctrl(32'hfeff_ffff);
    cmp_word(ctrl_rdata_out, 32'hb800_0720);
    cmp_bits({4'h0, cache_enable_out, store_buf_en_out, push_keep_valid_out,
              write_protect_out}, 8'h0f);
    for (int m = 0; m < 4; m++) begin
      wr_ctrl({22'h0, 2'(m), 8'h0});
      cmp_bits({3'h0, default_cache_mode_out, dflt_cacheable_out,
                dflt_copyback_out, dflt_precise_out},
               {3'h0, 2'(m), m < 2, m == 1, m != 3});
    end
  endtask
  task automatic t_sweep();
    wr_ctrl(32'h8000_0000);
    cmp_bits({7'h0, inval_clear_out}, 8'h0);
    access_req_in = 1'b1;
    wr_ctrl(32'h8100_0000);
    fork
      begin
        for (int i = 0; i < NSETS; i++) begin
          cmp_bits({inval_clear_out, inval_set_out}, {1'b1, 7'(i)});
          cmp_bits({5'h0, ctrl_rdata_out[24], access_stall_out,
                    alloc_done_out}, 8'h06);
          @(negedge clock_in);
        end
        cmp_bits({5'h0, inval_clear_out, ctrl_rdata_out[24],
                  access_stall_out}, 8'h0);
      end
      do_alloc(1'b0, 4'h1);
    join
    access_req_in = 1'b0;
  endtask
  task automatic t_fill();
    logic [2:0] s;
    wr_ctrl(32'h0);
    core.fetch(1'b1, 2'h0, LINE_A, 0, s);
    cmp_bits({5'h0, s}, 8'h01);
    wr_ctrl(32'h0000_0400);
    core.fetch(1'b1, 2'h0, LINE_A, 4, s);
    cmp_bits({5'h0, s}, 8'h02);
    core.fetch(1'b1, 2'h0, LINE_A, 0, s);
    cmp_bits({5'h0, s}, 8'h04);
    for (int t = 1; t < 4; t++) begin
      core.fetch(1'b1, 2'(t), LINE_A, 0, s);
      cmp_bits({5'h0, s}, 8'h01);
    end
    @(negedge clock_in);
    op_write_in = 1'b1;
    op_line_in  = LINE_A;
    @(negedge clock_in);
    op_write_in = 1'b0;
    op_line_in  = ~LINE_A;
    core.fetch(1'b1, 2'h0, LINE_A, 0, s);
    cmp_bits({5'h0, s}, 8'h04);
    @(negedge clock_in);
    line_fill_in = 1'b1;
    @(negedge clock_in);
    line_fill_in = 1'b0;
    core.fetch(1'b1, 2'h0, LINE_A, 0, s);
    cmp_bits({5'h0, s}, 8'h02);
    wr_ctrl(32'h8000_0000);
    core.fetch(1'b1, 2'h0, LINE_A, 0, s);
    cmp_bits({5'h0, s}, 8'h01);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clock_in           = 1'b0;
    rst_n_in           = 1'b0;
    ctrl_wr_in         = 1'b0;
    ctrl_wdata_in      = 32'h0;
    access_req_in      = 1'b0;
    alloc_req_in       = 1'b0;
    alloc_way_valid_in = 4'h0;
    line_fill_in       = 1'b0;
    op_write_in        = 1'b0;
    op_line_in         = 28'h0;
    bad_count          = 0;
    checks             = 0;
    t_reset();
    t_fields();
    foreach (PLAIN[i]) do_alloc(1'b0, PLAIN[i]);
    foreach (LOCKED[i]) do_alloc(LOCKED[i][4], LOCKED[i][3:0]);
    t_sweep();
    t_fill();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
